// ==== logic/mcst_pkg.sv ====
// Constants, states and pin groups for the module control and status block
package mcst_pkg;
	localparam int CLK_PERIOD_NS = 100;
	localparam int NS_PER_US = 1000;
	localparam int NS_PER_MS = 1000000;

	// Printed times, each in its own unit
	localparam int T_OFF_US = 10;
	localparam int T_ON_MS = 2;
	localparam int T_INIT_MS = 300;
	localparam int T_INT_ON_MS = 200;
	localparam int T_INT_OFF_US = 500;
	localparam int T_PD_ON_US = 100;
	localparam int T_PD_OFF_MS = 300;
	localparam int T_RST_MIN_US = 10;
	localparam int T_NR_ON_MS = 1;
	localparam int T_NR_OFF_MS = 1;
	localparam int T_DESEL_MS = 2;
	localparam int T_SEL_MS = 2;
	localparam int T_LOS_ON_US = 100;
	localparam int T_LOS_OFF_MIN_NS = 2300;
	localparam int T_LOS_OFF_MAX_US = 100;
	localparam int F_MGMT_MAX_KHZ = 400;

	// Longest times round down, least times round up
	localparam int T_OFF_CYC = T_OFF_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int T_ON_CYC = T_ON_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int T_INIT_CYC = T_INIT_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int T_INT_ON_CYC = T_INT_ON_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int T_INT_OFF_CYC = T_INT_OFF_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int T_PD_ON_CYC = T_PD_ON_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int T_PD_OFF_CYC = T_PD_OFF_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int T_RST_MIN_CYC =
		(T_RST_MIN_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_NR_ON_CYC = T_NR_ON_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int T_NR_OFF_CYC = T_NR_OFF_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int T_DESEL_CYC = T_DESEL_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int T_SEL_CYC = T_SEL_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int T_LOS_ON_CYC = T_LOS_ON_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int T_LOS_OFF_MIN_CYC =
		(T_LOS_OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_LOS_OFF_MAX_CYC =
		T_LOS_OFF_MAX_US * NS_PER_US / CLK_PERIOD_NS;

	// Filter settings and init count slack used by the block
	localparam int TX_ON_DLY_CYC = 1000;
	localparam int TX_OFF_DLY_CYC = 1;
	localparam int LOS_ON_DLY_CYC = 1;
	localparam int LOS_OFF_DLY_CYC = T_LOS_OFF_MIN_CYC + 1;
	localparam int INIT_EDGE_SLACK = 3;

	// Reset values
	localparam logic LASER_RST = 1'b0;
	localparam logic LOS_RST = 1'b1;

	typedef enum logic [1:0] {
		MCST_OFF = 2'b00,
		MCST_INIT = 2'b01,
		MCST_READY = 2'b11,
		MCST_PDOWN = 2'b10
	} mcst_state_e;

	typedef struct packed {
		logic transmit_disable_in;
		logic module_deselect_in;
		logic power_down_in;
	} mcst_host_s;
endpackage : mcst_pkg

// ==== logic/mcst_filter.sv ====
// Level filter with separate settle counts for rising and falling input
`timescale 1ns/1ns
module mcst_filter #(
	parameter int RISE = 1,
	parameter int FALL = 1,
	parameter logic RST_VAL = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic lvl_in,
	output logic lvl_out
);
	localparam int MX = (RISE > FALL) ? RISE : FALL;
	localparam int CW = $clog2(MX + 1);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] lim;

	// Output moves only after the input held the new level long enough
	assign lim = lvl_out ? CW'(FALL - 1) : CW'(RISE - 1);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
		end else if (lvl_in == lvl_out || cnt_reg == lim) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_reg + CW'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lvl_out <= RST_VAL;
		end else if (lvl_in != lvl_out && cnt_reg == lim) begin
			lvl_out <= lvl_in;
		end
	end
endmodule : mcst_filter

// ==== logic/mcst_top.sv ====
// Low-speed control and status timing of the pluggable optical module
`timescale 1ns/1ns
module mcst_top #(
	parameter int INIT_CYC = mcst_pkg::T_INIT_CYC,
	parameter int TX_ON_CYC = mcst_pkg::TX_ON_DLY_CYC,
	parameter int TX_ON_MAX_CYC = mcst_pkg::T_ON_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire mcst_pkg::mcst_host_s host,
	input wire logic supply_good_in,
	input wire logic fault_in,
	input wire logic signal_present_in,
	input wire logic int_event_in,
	input wire logic flag_read_in,
	output logic laser_on_out,
	output logic module_not_ready_out,
	output logic transmit_not_ready_out,
	output logic receive_signal_lost_out,
	output logic interrupt_out,
	output logic int_flag_out,
	output logic mgmt_enable_out,
	output logic powered_down_out
);
	import mcst_pkg::*;

	localparam int IW = $clog2(INIT_CYC + 1);
	localparam int PW = $clog2(T_RST_MIN_CYC + 1);
	localparam int OW = $clog2(TX_ON_MAX_CYC + 2);

	mcst_state_e state_reg;
	logic [IW-1:0] init_cnt_reg;
	logic [PW-1:0] pd_cnt_reg;
	logic resume_reg;
	logic laser_req;
	logic pd_long;
	logic init_done;

	// Entry edge already saw the request, so the count lags one sample
	assign pd_long = (pd_cnt_reg == PW'(T_RST_MIN_CYC - 1));
	assign init_done = (init_cnt_reg == IW'(INIT_CYC - INIT_EDGE_SLACK));

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= MCST_OFF;
		end else begin
			unique case (state_reg)
				MCST_OFF: begin
					if (supply_good_in && !host.power_down_in) begin
						state_reg <= MCST_INIT;
					end
				end
				MCST_INIT: begin
					if (!supply_good_in) begin
						state_reg <= MCST_OFF;
					end else if (host.power_down_in) begin
						state_reg <= MCST_PDOWN;
					end else if (init_done) begin
						state_reg <= MCST_READY;
					end
				end
				MCST_READY: begin
					if (!supply_good_in) begin
						state_reg <= MCST_OFF;
					end else if (host.power_down_in) begin
						state_reg <= MCST_PDOWN;
					end
				end
				MCST_PDOWN: begin
					if (!supply_good_in) begin
						state_reg <= MCST_OFF;
					end else if (!host.power_down_in) begin
						state_reg <= (pd_long || !resume_reg) ?
							MCST_INIT : MCST_READY;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			init_cnt_reg <= '0;
		end else if (state_reg == MCST_INIT && !init_done) begin
			init_cnt_reg <= init_cnt_reg + IW'(1);
		end else begin
			init_cnt_reg <= '0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pd_cnt_reg <= '0;
		end else if (state_reg != MCST_PDOWN) begin
			pd_cnt_reg <= '0;
		end else if (host.power_down_in && !pd_long) begin
			pd_cnt_reg <= pd_cnt_reg + PW'(1);
		end
	end

	// A glitch during init must still finish the init, so remember origin
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			resume_reg <= 1'b0;
		end else if (state_reg != MCST_PDOWN) begin
			resume_reg <= (state_reg == MCST_READY);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			powered_down_out <= 1'b1;
		end else begin
			powered_down_out <= (state_reg == MCST_PDOWN) ||
				(state_reg == MCST_OFF);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			module_not_ready_out <= 1'b1;
		end else begin
			module_not_ready_out <= fault_in || (state_reg != MCST_READY);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			transmit_not_ready_out <= 1'b0;
		end else begin
			transmit_not_ready_out <= fault_in;
		end
	end

	assign laser_req = !host.transmit_disable_in && !fault_in &&
		(state_reg == MCST_READY);

	// Turn-on waits for bias to settle; turn-off is immediate for safety
	// Delayed turn-on
	mcst_filter #(
		.RISE(TX_ON_CYC),
		.FALL(TX_OFF_DLY_CYC),
		.RST_VAL(LASER_RST)
	) u_laser (
		.ref_clk(ref_clk),
		.rst(rst),
		.lvl_in(laser_req),
		.lvl_out(laser_on_out)
	);

	mcst_filter #(
		.RISE(LOS_ON_DLY_CYC),
		.FALL(LOS_OFF_DLY_CYC),
		.RST_VAL(LOS_RST)
	) u_los (
		.ref_clk(ref_clk),
		.rst(rst),
		.lvl_in(!signal_present_in),
		.lvl_out(receive_signal_lost_out)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			int_flag_out <= 1'b0;
		end else if (int_event_in) begin
			int_flag_out <= 1'b1;
		end else if (flag_read_in) begin
			int_flag_out <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			interrupt_out <= 1'b0;
		end else begin
			interrupt_out <= int_flag_out;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mgmt_enable_out <= 1'b0;
		end else begin
			// No clock timeout; any slow rate accepted
			mgmt_enable_out <= !host.module_deselect_in &&
				(state_reg != MCST_OFF) && (state_reg != MCST_PDOWN);
		end
	end

	// Helper: cycles laser is requested but still dark
	logic [OW-1:0] on_wait_reg;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			on_wait_reg <= '0;
		end else if (!laser_req || laser_on_out) begin
			on_wait_reg <= '0;
		end else if (on_wait_reg != OW'(TX_ON_MAX_CYC + 1)) begin
			on_wait_reg <= on_wait_reg + OW'(1);
		end
	end

	property p_tx_off;
		@(posedge ref_clk) disable iff (rst)
		host.transmit_disable_in |=> !laser_on_out;
	endproperty
	a_tx_off: assert property (p_tx_off)
		else $error("Laser still on after disable");

	property p_tx_on;
		@(posedge ref_clk) disable iff (rst)
		on_wait_reg <= OW'(TX_ON_MAX_CYC);
	endproperty
	a_tx_on: assert property (p_tx_on)
		else $error("Laser turn-on too slow");

	property p_init_len;
		@(posedge ref_clk) disable iff (rst)
		(state_reg == MCST_INIT) |-> init_cnt_reg < IW'(INIT_CYC);
	endproperty
	a_init_len: assert property (p_init_len)
		else $error("Initialization overran");

	property p_int_on;
		@(posedge ref_clk) disable iff (rst)
		int_event_in |-> ##2 interrupt_out;
	endproperty
	a_int_on: assert property (p_int_on)
		else $error("Interrupt not raised");

	property p_int_off;
		@(posedge ref_clk) disable iff (rst)
		flag_read_in && !int_event_in |=> !int_flag_out ##1 !interrupt_out;
	endproperty
	a_int_off: assert property (p_int_off)
		else $error("Interrupt not cleared on read");

	property p_pd_on;
		@(posedge ref_clk) disable iff (rst)
		host.power_down_in |-> ##2 powered_down_out;
	endproperty
	a_pd_on: assert property (p_pd_on)
		else $error("Power-down not entered");

	property p_fault_nr;
		@(posedge ref_clk) disable iff (rst)
		fault_in |=> module_not_ready_out && transmit_not_ready_out;
	endproperty
	a_fault_nr: assert property (p_fault_nr)
		else $error("Not-ready missed fault");

	property p_nr_off;
		@(posedge ref_clk) disable iff (rst)
		!fault_in && state_reg == MCST_READY |=> !module_not_ready_out &&
			!transmit_not_ready_out;
	endproperty
	a_nr_off: assert property (p_nr_off)
		else $error("Not-ready held after recovery");

	property p_sel;
		@(posedge ref_clk) disable iff (rst)
		!host.module_deselect_in && state_reg == MCST_READY |=>
			mgmt_enable_out;
	endproperty
	a_sel: assert property (p_sel)
		else $error("Management not restored");

	property p_nr_hold;
		@(posedge ref_clk) disable iff (rst)
		(state_reg != MCST_READY) |=> module_not_ready_out;
	endproperty
	a_nr_hold: assert property (p_nr_hold)
		else $error("Not-ready released early");

	property p_desel;
		@(posedge ref_clk) disable iff (rst)
		host.module_deselect_in |=> !mgmt_enable_out;
	endproperty
	a_desel: assert property (p_desel)
		else $error("Management active while deselected");

	property p_los_on;
		@(posedge ref_clk) disable iff (rst)
		!signal_present_in |=> receive_signal_lost_out;
	endproperty
	a_los_on: assert property (p_los_on)
		else $error("Loss of signal not flagged");

	property p_los_min;
		@(posedge ref_clk) disable iff (rst)
		$fell(receive_signal_lost_out) |->
			$past(signal_present_in, 23) && $past(signal_present_in, 1);
	endproperty
	a_los_min: assert property (p_los_min)
		else $error("Loss flag dropped too soon");

	property p_los_max;
		@(posedge ref_clk) disable iff (rst)
		signal_present_in [*8] ##1 signal_present_in [*8]
			##1 signal_present_in [*8] |-> ##[0:2] !receive_signal_lost_out;
	endproperty
	a_los_max: assert property (p_los_max)
		else $error("Loss flag held too long");
endmodule : mcst_top

// ==== bench/mcst_host_model.sv ====
// Host line-card controller model driving the module's low-speed pins
`timescale 1ns/1ns
module mcst_host_model
	import mcst_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tx_req,
	input wire logic desel_req,
	input wire logic pd_req,
	output mcst_pkg::mcst_host_s host
);
	logic pd_prev_reg;
	int pd_cnt_reg;
	// stretch power-down
	// Short requests are widened so the module always sees a full reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pd_prev_reg <= 1'b0;
			pd_cnt_reg <= 0;
		end else begin
			pd_prev_reg <= pd_req;
			if (pd_req && !pd_prev_reg) begin
				pd_cnt_reg <= T_RST_MIN_CYC - 1;
			end else if (pd_cnt_reg != 0) begin
				pd_cnt_reg <= pd_cnt_reg - 1;
			end
		end
	end
	// Bus clock not modelled; any rate
	assign host = {tx_req, desel_req, pd_req | (pd_cnt_reg != 0)};
endmodule : mcst_host_model

// ==== bench/testbench.sv ====
// Self-checking bench for the module control and status block
`timescale 1ns/1ns
module testbench;
	import mcst_pkg::*;
	localparam int INIT = 20;
	typedef struct packed {
		int due;
		logic [7:0] mask;
		logic [7:0] val;
	} mcst_note_s;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic tx = 1'b0, desel = 1'b0, pd = 1'b0, supply = 1'b1;
	logic fault = 1'b0, present = 1'b1, ev = 1'b0, rd = 1'b0;
	logic r;
	mcst_host_s host;
	wire [7:0] outs;
	mcst_note_s notes[$];
	mcst_note_s nt;
	int cyc = 0;
	int fail_count = 0;
	int tests_run = 0;
	always #50 ref_clk = ~ref_clk;
	mcst_host_model host_model (.ref_clk(ref_clk), .rst(rst), .tx_req(tx),
		.desel_req(desel), .pd_req(pd), .host(host));
	mcst_top #(.INIT_CYC(INIT), .TX_ON_CYC(5), .TX_ON_MAX_CYC(10)) DUT (
		.ref_clk(ref_clk), .rst(rst), .host(host),
		.supply_good_in(supply), .fault_in(fault),
		.signal_present_in(present), .int_event_in(ev),
		.flag_read_in(rd), .laser_on_out(outs[7]),
		.module_not_ready_out(outs[6]), .transmit_not_ready_out(outs[5]),
		.receive_signal_lost_out(outs[4]), .interrupt_out(outs[3]),
		.int_flag_out(outs[2]), .mgmt_enable_out(outs[1]),
		.powered_down_out(outs[0]));
	task complete_run;
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run
	task check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t outputs %b expected %b", $time, seen, exp);
		end
	endtask : check
	task note(input int d, input logic [7:0] m, input logic [7:0] v);
		notes.push_back('{cyc + d, m, v});
	endtask : note
	task go(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : go
	// Notes fall due in order, so only the oldest is ever compared
	always @(negedge ref_clk) begin
		while (notes.size() > 0 && notes[0].due == cyc) begin
			nt = notes.pop_front();
			check(outs & nt.mask, nt.val);
		end
		cyc++;
	end
	initial begin
		#500000;
		fail_count++;
		complete_run();
	end
	initial begin
		void'($urandom(14147));
		note(3, 8'hff, 8'h51);
		go(8);
		rst <= 1'b0;
		note(5, 8'h01, 8'h00);
		note(INIT - 6, 8'h40, 8'h40);
		note(INIT + 4, 8'h40, 8'h00);
		note(INIT + 16, 8'hc2, 8'h82);
		go(INIT + 18);
		tx <= 1'b1;
		note(4, 8'h80, 8'h00);
		go(6);
		tx <= 1'b0;
		note(11, 8'h80, 8'h80);
		go(12);
		ev <= 1'b1;
		note(4, 8'h0c, 8'h0c);
		go(1);
		ev <= 1'b0;
		go(5);
		rd <= 1'b1;
		note(4, 8'h0c, 8'h00);
		go(1);
		rd <= 1'b0;
		go(5);
		fault <= 1'b1;
		note(4, 8'h60, 8'h60);
		go(6);
		fault <= 1'b0;
		note(4, 8'h60, 8'h00);
		go(6);
		present <= 1'b0;
		note(3, 8'h10, 8'h10);
		go(6);
		present <= 1'b1;
		note(T_LOS_OFF_MIN_CYC - 1, 8'h10, 8'h10);
		note(T_LOS_OFF_MIN_CYC + 7, 8'h10, 8'h00);
		go(32);
		desel <= 1'b1;
		note(4, 8'h02, 8'h00);
		go(6);
		desel <= 1'b0;
		note(4, 8'h02, 8'h02);
		go(6);
		pd <= 1'b1;
		note(6, 8'h41, 8'h41);
		go(1);
		pd <= 1'b0;
		note(T_RST_MIN_CYC + 8, 8'h41, 8'h40);
		note(T_RST_MIN_CYC + INIT + 12, 8'h41, 8'h00);
		go(T_RST_MIN_CYC + INIT + 30);
		// Random transmit-disable levels, each held long enough to settle
		for (int i = 0; i < 8; i++) begin
			r = 1'($urandom_range(0, 1));
			tx <= r;
			note(14, 8'h80, r ? 8'h00 : 8'h80);
			go(15);
		end
		// Supply loss and return must rerun initialization
		supply <= 1'b0;
		note(4, 8'h43, 8'h41);
		go(6);
		supply <= 1'b1;
		note(INIT - 6, 8'h41, 8'h40);
		note(INIT + 4, 8'h41, 8'h00);
		go(INIT + 6);
		complete_run();
	end
endmodule : testbench
